// *** src/srpc_map.vh ***
/*
 * register map of the system reset and power control block: offsets,
 * field positions, reset values and timings in nanoseconds.
 * assumes a 16-bit management register port addressed by 16-bit offsets.
 */
`ifndef SRPC_MAP_VH
`define SRPC_MAP_VH

`define SRPC_ADDR_IRQ_FLAGS       16'h0010
`define SRPC_ADDR_IRQ_MASK        16'h0020
`define SRPC_ADDR_SOFT_RESET      16'h8810
`define SRPC_ADDR_SOFT_PD         16'h8812
`define SRPC_ADDR_PHY_RESET       16'h8814
`define SRPC_ADDR_MAC_RESET       16'h8815
`define SRPC_ADDR_SYS_STATUS      16'h8818
`define SRPC_ADDR_PMG_CTRL        16'h8819
`define SRPC_ADDR_DIAG_CLK        16'h882C

`define SRPC_BIT_SW_IRQ           15
`define SRPC_BIT_HRD_RST_IRQ      12
`define SRPC_BIT_PD_REACHED       1
`define SRPC_BIT_STARTUP_DONE     0

`define SRPC_RST_IRQ_MASK         16'h1FFE
`define SRPC_RST_IRQ_FLAGS        16'h1000
`define SRPC_RST_DIAG_CLK         16'h0002
`define SRPC_MASK_WRITABLE        16'h1FFF
`define SRPC_FLAGS_LIVE           16'h9000

`define SRPC_STARTUP_NS           2000
`define SRPC_SUBRESET_NS          400
`define SRPC_SOFTRESET_NS         800
`define SRPC_CLK_NS               40

`endif

// *** src/srpc_pulse_timer.v ***
/*
 * srpc_pulse_timer: holds a busy level for a fixed number of cycles after
 * a start pulse; a new start while busy restarts the count.
 * assumes start comes from logic on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

module srpc_pulse_timer #(
    parameter CYCLES = 10
) (
    input  wire clk_in,
    input  wire rst_in,
    input  wire ce_in,
    input  wire start_in,
    output reg  busy_out
);
    reg [15:0] count_q;

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_q  <= 16'h0000;
            busy_out <= 1'b0;
        end else if (ce_in) begin
            if (start_in) begin
                count_q  <= CYCLES[15:0];
                busy_out <= 1'b1;
            end else if (count_q != 16'h0000) begin
                count_q  <= count_q - 16'h0001;
                busy_out <= (count_q != 16'h0001);
            end
        end
    end
endmodule

`default_nettype wire

// *** src/srpc_top.v ***
/*
 * srpc_top: system reset and power control registers. holds the interrupt
 * mask and latched flags, soft chip reset, software power-down, phy and
 * mac-interface resets, system status, boot oscillator force and the
 * diagnostics clock enable.
 * assumes a synchronous 16-bit management register port: a write strobe
 * or read strobe with an address for one cycle, read data on the next.
 * the strap pin is asynchronous and is synchronised here.
 */
`timescale 1ns/1ns
`default_nettype none
`include "srpc_map.vh"

// Overview of operation
// - writing one to mask bit 15 raises software interrupt; reads zero.
// - hardware reset interrupt enable resets to one; clearing cannot hide reset event.
// - mask gates interrupt output per event; resets to 0x1FFE, low bits writable.
// - soft reset bit reinitialises chip like hardware reset, then self-clears.
// - software power-down switches most circuitry off; registers stay accessible.
// - software power-down reset value comes from the strap pin.
// - phy subsystem reset bit starts managed reset, self-clears on completion.
// - mac interface reset bit starts managed reset, self-clears on completion.
// - status bit 1 high only while in software power-down.
// - status bit 0 high once start-up sequence completes, except while in software power-down or soft reset.
// - power management bit 0 forces boot oscillator clock on.
// - diagnostics bit 0 enables diagnostics clock; register resets to two.
// - status flags latch on events regardless of mask, clear on read.
// - hardware reset flag reads one after reset; software event in bit 15.
module srpc_top #(
    parameter STARTUP_CYCLES   = (`SRPC_STARTUP_NS + `SRPC_CLK_NS - 1) / `SRPC_CLK_NS,
    parameter SUBRESET_CYCLES  = (`SRPC_SUBRESET_NS + `SRPC_CLK_NS - 1) / `SRPC_CLK_NS,
    parameter SOFTRESET_CYCLES = (`SRPC_SOFTRESET_NS + `SRPC_CLK_NS - 1) / `SRPC_CLK_NS
) (
    // clock, reset, enable
    input  wire        SYS_CLK_IN,
    input  wire        SYS_RST_IN,
    input  wire        CLK_EN_IN,
    // strap
    input  wire        POWERDOWN_STRAP_PIN_IN,
    // management register port
    input  wire        REG_WR_IN,
    input  wire        REG_RD_IN,
    input  wire [15:0] REG_ADDR_IN,
    input  wire [15:0] REG_WDATA_IN,
    output reg  [15:0] REG_RDATA_OUT,
    output reg         REG_RVALID_OUT,
    // system controls
    output reg         IRQ_OUT,
    output reg         CHIP_RESET_OUT,
    output reg         PHY_SUBSYSTEM_RESET_OUT,
    output reg         MAC_INTERFACE_RESET_OUT,
    output reg         POWERDOWN_OUT,
    output reg         FORCE_BOOT_OSC_CLOCK_OUT,
    output reg         DIAGNOSTICS_CLOCK_ENABLE_OUT
);
    localparam ST_STARTUP  = 2'b00;
    localparam ST_RUN      = 2'b01;
    localparam ST_PWRDOWN  = 2'b10;
    localparam ST_SOFTRST  = 2'b11;

    // strap synchroniser
    reg        strap_meta_q;
    reg        strap_sync_q;
    reg        strap_taken_q;
    reg [1:0]  strap_wait_q;

    reg [1:0]  state_q;
    reg [1:0]  state_d;
    reg [15:0] count_q;
    reg [15:0] count_d;

    reg [12:0] irq_enable_mask_q;
    reg [15:0] irq_latched_flags_q;
    reg        software_irq_event_q;
    reg        soft_powerdown_q;
    reg        force_boot_osc_clock_q;
    reg        diagnostics_clock_enable_q;
    reg        phy_start_q;
    reg        mac_start_q;
    reg        soft_rst_start_q;

    wire       phy_busy;
    wire       mac_busy;
    wire       wr_ok;
    wire       rd_flags;
    wire [15:0] flags_set;
    wire [15:0] irq_gate;

    function is_addr;
        input [15:0] a;
        input [15:0] b;
        begin
            is_addr = (a == b);
        end
    endfunction

    assign wr_ok    = REG_WR_IN & CLK_EN_IN;
    assign rd_flags = REG_RD_IN & CLK_EN_IN & is_addr(REG_ADDR_IN, `SRPC_ADDR_IRQ_FLAGS);
    assign flags_set = {software_irq_event_q, 15'h0000};
    // software and hard reset events pass unmasked: the hard reset enable
    // is reinitialised by the very reset that it reports
    assign irq_gate  = {1'b1, 2'b00, 1'b1, irq_enable_mask_q[11:0]};

    srpc_pulse_timer #(
        .CYCLES (SUBRESET_CYCLES)
    ) u_phy_timer (
        .clk_in   (SYS_CLK_IN),
        .rst_in   (SYS_RST_IN),
        .ce_in    (CLK_EN_IN),
        .start_in (phy_start_q),
        .busy_out (phy_busy)
    );

    srpc_pulse_timer #(
        .CYCLES (SUBRESET_CYCLES)
    ) u_mac_timer (
        .clk_in   (SYS_CLK_IN),
        .rst_in   (SYS_RST_IN),
        .ce_in    (CLK_EN_IN),
        .start_in (mac_start_q),
        .busy_out (mac_busy)
    );

    // strap passes two flops before it is used
    always @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            strap_meta_q <= 1'b0;
            strap_sync_q <= 1'b0;
        end else if (CLK_EN_IN) begin
            strap_meta_q <= POWERDOWN_STRAP_PIN_IN;
            strap_sync_q <= strap_meta_q;
        end
    end

    // start-up and soft reset sequencing
    always @* begin
        state_d = state_q;
        count_d = count_q;
        case (state_q)
            ST_STARTUP: begin
                if (count_q != 16'h0000) begin
                    count_d = count_q - 16'h0001;
                end else begin
                    state_d = soft_powerdown_q ? ST_PWRDOWN : ST_RUN;
                end
            end
            ST_RUN: begin
                if (soft_rst_start_q) begin
                    state_d = ST_SOFTRST;
                    count_d = SOFTRESET_CYCLES[15:0];
                end else if (soft_powerdown_q) begin
                    state_d = ST_PWRDOWN;
                end
            end
            ST_PWRDOWN: begin
                if (soft_rst_start_q) begin
                    state_d = ST_SOFTRST;
                    count_d = SOFTRESET_CYCLES[15:0];
                end else if (!soft_powerdown_q) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                if (count_q != 16'h0000) begin
                    count_d = count_q - 16'h0001;
                end else begin
                    state_d = ST_STARTUP;
                    count_d = STARTUP_CYCLES[15:0];
                end
            end
        endcase
    end

    always @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            state_q <= ST_STARTUP;
            count_q <= 16'h0000;
        end else if (CLK_EN_IN) begin
            if (!strap_taken_q) begin
                count_q <= STARTUP_CYCLES[15:0];
            end else begin
                state_q <= state_d;
                count_q <= count_d;
            end
        end
    end

    // register writes, self-clearing strobes and soft reset reinitialisation
    always @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            strap_taken_q              <= 1'b0;
            strap_wait_q               <= 2'b00;
            irq_enable_mask_q          <= 13'h1FFE;
            software_irq_event_q       <= 1'b0;
            soft_powerdown_q           <= 1'b0;
            force_boot_osc_clock_q     <= 1'b0;
            diagnostics_clock_enable_q <= 1'b0;
            phy_start_q                <= 1'b0;
            mac_start_q                <= 1'b0;
            soft_rst_start_q           <= 1'b0;
        end else if (CLK_EN_IN) begin
            software_irq_event_q <= 1'b0;
            phy_start_q          <= 1'b0;
            mac_start_q          <= 1'b0;
            soft_rst_start_q     <= 1'b0;
            if (!strap_taken_q) begin
                // wait two edges so the strap has crossed both sync stages;
                // only the second stage is read, never the first
                if (strap_wait_q == 2'b10) begin
                    strap_taken_q    <= 1'b1;
                    soft_powerdown_q <= strap_sync_q;
                end else begin
                    strap_wait_q <= strap_wait_q + 2'b01;
                end
            end else if (state_q == ST_SOFTRST) begin
                // soft reset restores control state; strap is taken again
                irq_enable_mask_q          <= 13'h1FFE;
                force_boot_osc_clock_q     <= 1'b0;
                diagnostics_clock_enable_q <= 1'b0;
                // drop the strap flag only on the last count, else the
                // sequencer would restart the soft reset for ever
                if (count_q == 16'h0000) begin
                    strap_taken_q <= 1'b0;
                    strap_wait_q  <= 2'b00;
                end
            end else if (wr_ok) begin
                if (is_addr(REG_ADDR_IN, `SRPC_ADDR_IRQ_MASK)) begin
                    irq_enable_mask_q    <= REG_WDATA_IN[12:0];
                    software_irq_event_q <= REG_WDATA_IN[`SRPC_BIT_SW_IRQ];
                end else if (is_addr(REG_ADDR_IN, `SRPC_ADDR_SOFT_RESET)) begin
                    soft_rst_start_q <= REG_WDATA_IN[0];
                end else if (is_addr(REG_ADDR_IN, `SRPC_ADDR_SOFT_PD)) begin
                    soft_powerdown_q <= REG_WDATA_IN[0];
                end else if (is_addr(REG_ADDR_IN, `SRPC_ADDR_PHY_RESET)) begin
                    phy_start_q <= REG_WDATA_IN[0];
                end else if (is_addr(REG_ADDR_IN, `SRPC_ADDR_MAC_RESET)) begin
                    mac_start_q <= REG_WDATA_IN[0];
                end else if (is_addr(REG_ADDR_IN, `SRPC_ADDR_PMG_CTRL)) begin
                    force_boot_osc_clock_q <= REG_WDATA_IN[0];
                end else if (is_addr(REG_ADDR_IN, `SRPC_ADDR_DIAG_CLK)) begin
                    diagnostics_clock_enable_q <= REG_WDATA_IN[0];
                end
            end
        end
    end

    // latched flags: a set in the cycle of a clearing read wins
    always @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            irq_latched_flags_q <= `SRPC_RST_IRQ_FLAGS;
        end else if (CLK_EN_IN) begin
            if (strap_taken_q && state_q == ST_SOFTRST) begin
                // soft reset counts as a hardware reset event
                irq_latched_flags_q <= `SRPC_RST_IRQ_FLAGS;
            end else if (rd_flags) begin
                irq_latched_flags_q <= flags_set;
            end else begin
                irq_latched_flags_q <= irq_latched_flags_q | flags_set;
            end
        end
    end

    // read port and registered outputs
    always @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            REG_RDATA_OUT                <= 16'h0000;
            REG_RVALID_OUT               <= 1'b0;
            IRQ_OUT                      <= 1'b0;
            CHIP_RESET_OUT               <= 1'b1;
            PHY_SUBSYSTEM_RESET_OUT      <= 1'b0;
            MAC_INTERFACE_RESET_OUT      <= 1'b0;
            POWERDOWN_OUT                <= 1'b0;
            FORCE_BOOT_OSC_CLOCK_OUT     <= 1'b0;
            DIAGNOSTICS_CLOCK_ENABLE_OUT <= 1'b0;
        end else if (CLK_EN_IN) begin
            REG_RVALID_OUT <= REG_RD_IN;
            REG_RDATA_OUT  <= 16'h0000;
            if (REG_RD_IN) begin
                if (is_addr(REG_ADDR_IN, `SRPC_ADDR_IRQ_FLAGS)) begin
                    REG_RDATA_OUT <= irq_latched_flags_q;
                end else if (is_addr(REG_ADDR_IN, `SRPC_ADDR_IRQ_MASK)) begin
                    REG_RDATA_OUT <= {3'b000, irq_enable_mask_q};
                end else if (is_addr(REG_ADDR_IN, `SRPC_ADDR_SOFT_RESET)) begin
                    REG_RDATA_OUT <= {15'h0000, state_q == ST_SOFTRST};
                end else if (is_addr(REG_ADDR_IN, `SRPC_ADDR_SOFT_PD)) begin
                    REG_RDATA_OUT <= {15'h0000, soft_powerdown_q};
                end else if (is_addr(REG_ADDR_IN, `SRPC_ADDR_PHY_RESET)) begin
                    REG_RDATA_OUT <= {15'h0000, phy_busy | phy_start_q};
                end else if (is_addr(REG_ADDR_IN, `SRPC_ADDR_MAC_RESET)) begin
                    REG_RDATA_OUT <= {15'h0000, mac_busy | mac_start_q};
                end else if (is_addr(REG_ADDR_IN, `SRPC_ADDR_SYS_STATUS)) begin
                    REG_RDATA_OUT <= {14'h0000, state_q == ST_PWRDOWN,
                                      state_q == ST_RUN};
                end else if (is_addr(REG_ADDR_IN, `SRPC_ADDR_PMG_CTRL)) begin
                    REG_RDATA_OUT <= {15'h0000, force_boot_osc_clock_q};
                end else if (is_addr(REG_ADDR_IN, `SRPC_ADDR_DIAG_CLK)) begin
                    REG_RDATA_OUT <= `SRPC_RST_DIAG_CLK |
                                     {15'h0000, diagnostics_clock_enable_q};
                end
            end
            IRQ_OUT <= |(irq_latched_flags_q & irq_gate);
            CHIP_RESET_OUT               <= !strap_taken_q || state_q == ST_SOFTRST
                                            || state_q == ST_STARTUP;
            PHY_SUBSYSTEM_RESET_OUT      <= phy_busy;
            MAC_INTERFACE_RESET_OUT      <= mac_busy;
            POWERDOWN_OUT                <= state_q == ST_PWRDOWN;
            FORCE_BOOT_OSC_CLOCK_OUT     <= force_boot_osc_clock_q;
            DIAGNOSTICS_CLOCK_ENABLE_OUT <= diagnostics_clock_enable_q;
        end
    end
endmodule

`default_nettype wire

// *** dv/srpc_host_model.sv ***
/*
 * srpc_host_model: host side of the management register port.
 * assumes one-cycle strobes and read data one cycle after the strobe.
 */
`timescale 1ns/1ns
`default_nettype none
module srpc_host_model (
    // clock
    input  wire logic        clk_in,
    // register port
    output var  logic        reg_wr_out,
    output var  logic        reg_rd_out,
    output var  logic [15:0] reg_addr_out,
    output var  logic [15:0] reg_wdata_out,
    input  wire logic [15:0] reg_rdata_in,
    input  wire logic        reg_rvalid_in
);
    initial begin
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_addr_out = 16'h0000;
        reg_wdata_out = 16'h0000;
    end
    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk_in);
        reg_addr_out = a;
        reg_wdata_out = d;
        reg_wr_out = 1'b1;
        @(negedge clk_in);
        reg_wr_out = 1'b0;
        // idle bus shows no stale value
        reg_addr_out = ~a;
        reg_wdata_out = ~d;
    endtask
    task automatic rd_reg(input logic [15:0] a, output logic [15:0] d, output logic ok);
        @(negedge clk_in);
        reg_addr_out = a;
        reg_rd_out = 1'b1;
        @(negedge clk_in);
        reg_rd_out = 1'b0;
        reg_addr_out = ~a;
        ok = reg_rvalid_in;
        d = reg_rdata_in;
    endtask
endmodule
`default_nettype wire

// *** dv/srpc_top_asserts.sv ***
/*
 * srpc_top_asserts: port checks for srpc_top.
 * assumes a single clock domain; bound to every srpc_top instance.
 */
`timescale 1ns/1ns
`default_nettype none
module srpc_top_asserts #(
    parameter SUBRESET_CYCLES = 10
) (
    // clock and reset
    input wire logic        SYS_CLK_IN,
    input wire logic        SYS_RST_IN,
    input wire logic        CLK_EN_IN,
    // register port
    input wire logic        REG_WR_IN,
    input wire logic        REG_RD_IN,
    input wire logic [15:0] REG_ADDR_IN,
    input wire logic [15:0] REG_WDATA_IN,
    input wire logic [15:0] REG_RDATA_OUT,
    input wire logic        REG_RVALID_OUT,
    // controls
    input wire logic        IRQ_OUT,
    input wire logic        CHIP_RESET_OUT,
    input wire logic        PHY_SUBSYSTEM_RESET_OUT
);
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    logic [7:0] phy_cnt_q;
    logic       wr_ok;
    // writes made while the chip reset is up are not checked
    assign wr_ok = REG_WR_IN && CLK_EN_IN && !CHIP_RESET_OUT;
    always @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN)
            phy_cnt_q <= 8'h00;
        else if (!PHY_SUBSYSTEM_RESET_OUT)
            phy_cnt_q <= 8'h00;
        else if (phy_cnt_q != 8'hFF)
            phy_cnt_q <= phy_cnt_q + 8'h01;
    end
    rd_answer_a: assert property ((REG_RD_IN && CLK_EN_IN) |=> REG_RVALID_OUT)
        else $error("read strobe got no answer");
    rvalid_cause_a: assert property ((REG_RVALID_OUT && $past(CLK_EN_IN))
        |-> $past(REG_RD_IN)) else $error("read answer without a read");
    rdata_idle_a: assert property (!REG_RVALID_OUT |-> REG_RDATA_OUT == 16'h0000)
        else $error("read data not zero when idle");
    mask_readback_a: assert property ((REG_RVALID_OUT && $past(REG_ADDR_IN) == 16'h0020)
        |-> REG_RDATA_OUT[15:13] == 3'h0) else $error("mask top bits not zero");
    status_bits_a: assert property ((REG_RVALID_OUT && $past(REG_ADDR_IN) == 16'h8818)
        |-> REG_RDATA_OUT[15:2] == 14'h0 && !(REG_RDATA_OUT[1] && REG_RDATA_OUT[0]))
        else $error("status bits inconsistent");
    phy_length_a: assert property ($fell(PHY_SUBSYSTEM_RESET_OUT)
        |-> phy_cnt_q >= SUBRESET_CYCLES) else $error("phy reset too short");
    phy_start_a: assert property ((wr_ok && REG_ADDR_IN == 16'h8814 && REG_WDATA_IN[0])
        |-> ##[1:4] PHY_SUBSYSTEM_RESET_OUT) else $error("phy reset not started");
    swirq_raise_a: assert property ((wr_ok && REG_ADDR_IN == 16'h0020 && REG_WDATA_IN[15])
        |-> ##[1:4] IRQ_OUT) else $error("software interrupt not raised");
    soft_reset_a: assert property ((wr_ok && REG_ADDR_IN == 16'h8810 && REG_WDATA_IN[0])
        |-> ##[1:4] CHIP_RESET_OUT) else $error("soft reset not started");
endmodule
bind srpc_top srpc_top_asserts #(.SUBRESET_CYCLES(SUBRESET_CYCLES)) i_srpc_top_asserts (
    .SYS_CLK_IN(SYS_CLK_IN), .SYS_RST_IN(SYS_RST_IN), .CLK_EN_IN(CLK_EN_IN),
    .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN), .REG_ADDR_IN(REG_ADDR_IN),
    .REG_WDATA_IN(REG_WDATA_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
    .REG_RVALID_OUT(REG_RVALID_OUT), .IRQ_OUT(IRQ_OUT), .CHIP_RESET_OUT(CHIP_RESET_OUT),
    .PHY_SUBSYSTEM_RESET_OUT(PHY_SUBSYSTEM_RESET_OUT)
);
`default_nettype wire

// *** dv/tb.sv ***
/*
 * tb: self-checking bench for srpc_top with a host model on the port.
 * assumes short timing parameters so the run stays brief.
 */
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam int STARTUP = 6;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        clk_en  = 1'b1;
    logic        strap   = 1'b0;
    logic        reg_wr, reg_rd, reg_rvalid;
    logic [15:0] reg_addr, reg_wdata, reg_rdata;
    logic        irq, chip_rst, phy_rst, mac_rst, pd, osc, diag;
    int          num_errors = 0;
    int          compares   = 0;
    always #20 sys_clk = ~sys_clk;
    srpc_top #(.STARTUP_CYCLES(STARTUP), .SUBRESET_CYCLES(3), .SOFTRESET_CYCLES(4)) i_srpc_top (
        .SYS_CLK_IN(sys_clk), .SYS_RST_IN(sys_rst), .CLK_EN_IN(clk_en),
        .POWERDOWN_STRAP_PIN_IN(strap), .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd),
        .REG_ADDR_IN(reg_addr), .REG_WDATA_IN(reg_wdata), .REG_RDATA_OUT(reg_rdata),
        .REG_RVALID_OUT(reg_rvalid), .IRQ_OUT(irq), .CHIP_RESET_OUT(chip_rst),
        .PHY_SUBSYSTEM_RESET_OUT(phy_rst), .MAC_INTERFACE_RESET_OUT(mac_rst),
        .POWERDOWN_OUT(pd), .FORCE_BOOT_OSC_CLOCK_OUT(osc), .DIAGNOSTICS_CLOCK_ENABLE_OUT(diag));
    srpc_host_model i_srpc_host_model (
        .clk_in(sys_clk), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd), .reg_addr_out(reg_addr),
        .reg_wdata_out(reg_wdata), .reg_rdata_in(reg_rdata), .reg_rvalid_in(reg_rvalid));
    task automatic test_done;
        if (num_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bit_chk(input logic s, input logic e);
        check({15'h0, s}, {15'h0, e});
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        i_srpc_host_model.wr_reg(a, d);
    endtask
    task automatic rdc(input logic [15:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic        ok;
        i_srpc_host_model.rd_reg(a, d, ok);
        bit_chk(ok, 1'b1);
        check(d, e);
    endtask
    task automatic do_reset(input logic s);
        strap = s;
        sys_rst = 1'b1;
        repeat (12) @(negedge sys_clk);
        sys_rst = 1'b0;
        bit_chk(chip_rst, 1'b1);
        rdc(16'h8818, 16'h0000);
        repeat (STARTUP + 12) @(negedge sys_clk);
    endtask
    task automatic t_reset_vals;
        logic [15:0] adr [10];
        logic [15:0] exv [10];
        adr = '{16'h0020, 16'h8810, 16'h8812, 16'h8814, 16'h8815,
                16'h8818, 16'h8819, 16'h882C, 16'h1234, 16'h0010};
        exv = '{16'h1FFE, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                16'h0001, 16'h0000, 16'h0002, 16'h0000, 16'h1000};
        bit_chk(irq, 1'b1);
        for (int i = 0; i < 10; i++) rdc(adr[i], exv[i]);
        rdc(16'h0010, 16'h0000);
        repeat (2) @(negedge sys_clk);
        bit_chk(irq, 1'b0);
    endtask
    task automatic t_mask;
        wr(16'h0020, 16'h0000);
        rdc(16'h0020, 16'h0000);
        bit_chk(irq, 1'b0);
        wr(16'h0020, 16'h8000);
        repeat (2) @(negedge sys_clk);
        bit_chk(irq, 1'b1);
        rdc(16'h0020, 16'h0000);
        rdc(16'h0010, 16'h8000);
        repeat (2) @(negedge sys_clk);
        bit_chk(irq, 1'b0);
        wr(16'h0020, 16'hFFFF);
        rdc(16'h0020, 16'h1FFF);
        rdc(16'h0010, 16'h8000);
    endtask
    task automatic t_subreset(input logic [15:0] a);
        int n;
        wr(a, 16'h0001);
        rdc(a, 16'h0001);
        bit_chk(a[0] ? mac_rst : phy_rst, 1'b1);
        n = 0;
        while ((a[0] ? mac_rst : phy_rst) && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        bit_chk(n < 50, 1'b1);
        rdc(a, 16'h0000);
    endtask
    task automatic t_clocks;
        wr(16'h8819, 16'h0001);
        wr(16'h882C, 16'hFFFF);
        rdc(16'h8819, 16'h0001);
        rdc(16'h882C, 16'h0003);
        bit_chk(osc, 1'b1);
        bit_chk(diag, 1'b1);
        wr(16'h882C, 16'h0000);
        rdc(16'h882C, 16'h0002);
        bit_chk(diag, 1'b0);
        // frozen clock enable must swallow the write
        clk_en = 1'b0;
        wr(16'h8819, 16'h0000);
        clk_en = 1'b1;
        rdc(16'h8819, 16'h0001);
    endtask
    task automatic t_soft;
        int n;
        wr(16'h0020, 16'h0000);
        wr(16'h8810, 16'h0001);
        rdc(16'h8810, 16'h0001);
        bit_chk(chip_rst, 1'b1);
        n = 0;
        while (chip_rst && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        bit_chk(n < 100, 1'b1);
        rdc(16'h8810, 16'h0000);
        rdc(16'h0020, 16'h1FFE);
        wr(16'h0020, 16'h0000);
        repeat (2) @(negedge sys_clk);
        bit_chk(irq, 1'b1);
        rdc(16'h0010, 16'h1000);
        rdc(16'h8819, 16'h0000);
        rdc(16'h8818, 16'h0001);
        bit_chk(osc, 1'b0);
    endtask
    task automatic t_pd;
        do_reset(1'b1);
        rdc(16'h8818, 16'h0002);
        rdc(16'h8812, 16'h0001);
        bit_chk(pd, 1'b1);
        rdc(16'h0020, 16'h1FFE);
        wr(16'h8812, 16'h0000);
        repeat (STARTUP + 4) @(negedge sys_clk);
        bit_chk(pd, 1'b0);
        rdc(16'h8818, 16'h0001);
        wr(16'h8812, 16'h0001);
        repeat (STARTUP + 4) @(negedge sys_clk);
        bit_chk(pd, 1'b1);
        rdc(16'h8818, 16'h0002);
    endtask
    initial begin
        repeat (5000) @(posedge sys_clk);
        num_errors++;
        test_done();
    end
    initial begin
        do_reset(1'b0);
        t_reset_vals();
        t_mask();
        t_subreset(16'h8814);
        t_subreset(16'h8815);
        t_clocks();
        t_soft();
        t_pd();
        test_done();
    end
endmodule
`default_nettype wire
